// ### design/lvrc_pkg.sv
// Package: register map, fields, reset values and types for the low-voltage reset control
package lvrc_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [5:0] OFF_PWR_CTRL = 6'h00;
	localparam logic [5:0] OFF_CAUSE = 6'h04;
	localparam logic [5:0] OFF_IRQ_STAT = 6'h08;
	localparam logic [5:0] OFF_IRQ_MASK = 6'h0c;
	localparam logic [5:0] OFF_VEC = 6'h10;
	localparam logic [5:0] OFF_STATE = 6'h14;
	localparam logic [5:0] OFF_DIRECT = 6'h18;
	localparam logic [5:0] OFF_SPARE0 = 6'h1c;
	localparam logic [5:0] OFF_SPARE1 = 6'h20;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int CTL_DETECT_EN = 0;
	localparam int CTL_STOP_EN = 1;
	localparam int CTL_RESET_EN = 2;
	localparam int CTL_THRESH_SEL = 3;
	localparam int CTL_WARN_IE = 4;
	localparam int CTL_WARN_FLAG = 5;
	localparam logic [7:0] CTL_RESET = 8'h1d;
	localparam logic [7:0] CTL_WMASK = 8'h1f;

	// ----------------------------------------
	// Cause register fields
	// ----------------------------------------
	localparam int CAU_POR = 7;
	localparam int CAU_PIN = 6;
	localparam int CAU_WDOG = 5;
	localparam int CAU_ILOP = 4;
	localparam int CAU_ILAD = 3;
	localparam int CAU_LVD = 1;
	localparam logic [7:0] CAUSE_POR_VAL = 8'h82;

	// ----------------------------------------
	// Interrupt status bits and vectors
	// ----------------------------------------
	localparam int IRQ_WARN = 0;
	localparam int IRQ_RESET = 1;
	localparam int IRQ_STOP_REFUSED = 2;
	localparam int NIRQ = 3;
	localparam logic [4:0] VEC_RESET = 5'h00;
	localparam logic [4:0] VEC_WARN = 5'h03;
	localparam logic [4:0] VEC_NONE = 5'h1f;
	localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;
	localparam logic [3:0] CMP_SYNC_RESET = 4'he;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_HOLD = 2'b01,
		ST_RELEASE = 2'b11
	} lvrc_state_t;

	typedef struct packed {
		logic por_low;
		logic lvd_low;
		logic lvd_high;
		logic warn;
	} lvrc_cmp_t;

	typedef struct packed {
		logic pin;
		logic wdog;
		logic ilop;
		logic ilad;
	} lvrc_src_t;

	typedef struct packed {
		logic stop_req;
		logic deep_stop_req;
	} lvrc_stop_t;

endpackage

// ### design/lvrc_top.sv
// Low-voltage reset control: detection gating, reset hold, cause and warning IRQ
// Contract
// - Detection is active only while the detect-enable bit is 1.
// - Entering any stop mode turns detection off unless detect-in-stop is set.
// - With detect-in-stop and detect enable both set, deep stop is refused.
// - A power-on comparator low asserts reset until supply passes the low level.
// - After power-on reset both the power-on and low-voltage cause flags set.
// - With low-voltage reset enabled, a low-voltage detect makes a system reset.
// - The threshold select bit chooses which detection level is compared.
// - After a low-voltage reset, reset holds until supply is above the threshold.
// - The low-voltage cause flag sets after a low-voltage or power-on reset.
// - A warning with warning IRQ enabled sets the warning flag and requests IRQ.
// - Control sits in one direct-page and eight high-page 8-bit registers.
// - A set flag with its local enable at 1 forwards a request to the CPU.
// - Among pending requests the lower vector number wins.
//
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module lvrc_top (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// Avalon-MM slave
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Comparators (asynchronous pins)
	input wire lvrc_pkg::lvrc_cmp_t cmp_i,
	// Other reset sources and stop requests from the core
	input wire lvrc_pkg::lvrc_src_t src_i,
	input wire lvrc_pkg::lvrc_stop_t stop_i,
	// To the core
	output logic cpu_reset_o,
	output logic [4:0] cpu_vector_o,
	output logic cpu_irq_o,
	output logic stop_granted_o,
	output logic deep_stop_granted_o,
	output logic detect_active_o
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Comparators are analog and async; two flops before any use
	logic [3:0] cmp_raw;
	logic [3:0] cmp_s1_reg;
	logic [3:0] cmp_s2_reg;
	lvrc_pkg::lvrc_cmp_t cmp;
	assign cmp_raw = cmp_i;
	// Flops reset to supply low so no release before the pins are seen
	for (genvar i = 0; i < 4; i++) begin : g_sync
		always_ff @(posedge clk_sys_i or negedge resetn_i) begin
			if (!resetn_i) begin
				cmp_s1_reg[i] <= lvrc_pkg::CMP_SYNC_RESET[i];
				cmp_s2_reg[i] <= lvrc_pkg::CMP_SYNC_RESET[i];
			end else begin
				cmp_s1_reg[i] <= cmp_raw[i];
				cmp_s2_reg[i] <= cmp_s1_reg[i];
			end
		end
	end
	assign cmp = lvrc_pkg::lvrc_cmp_t'(cmp_s2_reg);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] ctl_reg, ctl_next;
	logic [7:0] cause_reg, cause_next;
	logic [7:0] direct_reg, direct_next;
	logic [lvrc_pkg::NIRQ-1:0] stat_reg, stat_next;
	logic [lvrc_pkg::NIRQ-1:0] mask_reg, mask_next;
	logic in_stop_reg, in_stop_next;
	logic por_seen_reg, por_seen_next;
	logic [31:0] rdata_reg, rdata_next;
	logic ack_reg, ack_next;
	lvrc_pkg::lvrc_state_t st_reg, st_next;

	logic detect_on;
	logic lvd_trip;
	logic above_thr;
	logic deep_block;
	logic warn_evt;
	logic reset_evt;
	logic refuse_evt;
	logic wr_hit;
	logic any_src;

	// ----------------------------------------
	// Detection and stop gating
	// ----------------------------------------
	// Detection off in stop unless detect-in-stop is set
	assign detect_on = ctl_reg[lvrc_pkg::CTL_DETECT_EN]
		&& (!in_stop_reg || ctl_reg[lvrc_pkg::CTL_STOP_EN]);
	// Threshold select picks the high or the low detection level
	assign lvd_trip = ctl_reg[lvrc_pkg::CTL_THRESH_SEL] ? cmp.lvd_high
		: cmp.lvd_low;
	assign above_thr = !lvd_trip;
	assign deep_block = ctl_reg[lvrc_pkg::CTL_STOP_EN]
		&& ctl_reg[lvrc_pkg::CTL_DETECT_EN];
	assign any_src = src_i.pin | src_i.wdog | src_i.ilop | src_i.ilad;
	assign refuse_evt = stop_i.deep_stop_req && deep_block && !in_stop_reg;
	assign warn_evt = detect_on && cmp.warn
		&& ctl_reg[lvrc_pkg::CTL_WARN_IE];

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		reset_evt = 1'b0;
		cause_next = cause_reg;
		por_seen_next = por_seen_reg;
		case (st_reg)
			lvrc_pkg::ST_RUN: begin
				if (cmp.por_low) begin
					st_next = lvrc_pkg::ST_HOLD;
					por_seen_next = 1'b1;
					cause_next = lvrc_pkg::CAUSE_POR_VAL;
					reset_evt = 1'b1;
				end else if (detect_on && lvd_trip
					&& ctl_reg[lvrc_pkg::CTL_RESET_EN]) begin
					st_next = lvrc_pkg::ST_HOLD;
					por_seen_next = 1'b0;
					// Power-on flag unaffected by a low-voltage reset
					cause_next = {cause_reg[lvrc_pkg::CAU_POR], 5'h00,
						1'b1, 1'b0};
					reset_evt = 1'b1;
				end else if (any_src) begin
					st_next = lvrc_pkg::ST_HOLD;
					por_seen_next = 1'b0;
					cause_next = {1'b0, src_i.pin, src_i.wdog, src_i.ilop,
						src_i.ilad, 3'h0};
					reset_evt = 1'b1;
				end
			end
			lvrc_pkg::ST_HOLD: begin
				// Power-on waits for the low level, LVD for the selected one
				if (por_seen_reg ? !cmp.lvd_low && !cmp.por_low
					: above_thr && !any_src) begin
					st_next = lvrc_pkg::ST_RELEASE;
				end
			end
			lvrc_pkg::ST_RELEASE: begin
				st_next = lvrc_pkg::ST_RUN;
			end
			default: begin
				st_next = lvrc_pkg::ST_HOLD;
			end
		endcase
	end

	// ----------------------------------------
	// Registers and bus
	// ----------------------------------------
	// Writes land on the edge that ends the wait, as the master expects
	assign wr_hit = avs_write_i && ack_reg && avs_byteenable_i[0];

	always_comb begin
		ctl_next = ctl_reg;
		direct_next = direct_reg;
		stat_next = stat_reg;
		mask_next = mask_reg;
		in_stop_next = in_stop_reg;
		rdata_next = 32'h0000_0000;
		ack_next = 1'b0;
		if (st_reg != lvrc_pkg::ST_RUN) begin
			// Control returns to defaults while reset is held
			ctl_next = lvrc_pkg::CTL_RESET;
			in_stop_next = 1'b0;
		end else if (stop_i.stop_req) begin
			in_stop_next = 1'b1;
		end else if (stop_i.deep_stop_req && !deep_block) begin
			in_stop_next = 1'b1;
		end else if (!stop_i.stop_req && !stop_i.deep_stop_req) begin
			in_stop_next = 1'b0;
		end
		if ((avs_read_i || avs_write_i) && !ack_reg) begin
			ack_next = 1'b1;
		end
		if (wr_hit) begin
			case (avs_address_i)
				lvrc_pkg::OFF_PWR_CTRL: begin
					ctl_next = (ctl_reg & ~lvrc_pkg::CTL_WMASK)
						| (avs_writedata_i[7:0] & lvrc_pkg::CTL_WMASK);
					// Writing one acknowledges the warning flag
					if (avs_writedata_i[lvrc_pkg::CTL_WARN_FLAG]) begin
						ctl_next[lvrc_pkg::CTL_WARN_FLAG] = 1'b0;
					end
				end
				lvrc_pkg::OFF_IRQ_STAT: begin
					stat_next = stat_reg
						& ~avs_writedata_i[lvrc_pkg::NIRQ-1:0];
				end
				lvrc_pkg::OFF_IRQ_MASK: begin
					mask_next = avs_writedata_i[lvrc_pkg::NIRQ-1:0];
				end
				lvrc_pkg::OFF_DIRECT: begin
					direct_next = avs_writedata_i[7:0];
				end
				default: begin
				end
			endcase
		end
		// Sets override a same-cycle clear
		if (warn_evt) begin
			ctl_next[lvrc_pkg::CTL_WARN_FLAG] = 1'b1;
			stat_next[lvrc_pkg::IRQ_WARN] = 1'b1;
		end
		if (reset_evt) begin
			stat_next[lvrc_pkg::IRQ_RESET] = 1'b1;
		end
		if (refuse_evt) begin
			stat_next[lvrc_pkg::IRQ_STOP_REFUSED] = 1'b1;
		end
		if (avs_read_i && !ack_reg) begin
			case (avs_address_i)
				lvrc_pkg::OFF_PWR_CTRL: rdata_next = {24'h0, ctl_reg};
				lvrc_pkg::OFF_CAUSE: rdata_next = {24'h0, cause_reg};
				lvrc_pkg::OFF_IRQ_STAT: rdata_next = {29'h0, stat_reg};
				lvrc_pkg::OFF_IRQ_MASK: rdata_next = {29'h0, mask_reg};
				lvrc_pkg::OFF_VEC: rdata_next = {27'h0, cpu_vector_o};
				lvrc_pkg::OFF_STATE: rdata_next = {28'h0, in_stop_reg,
					detect_on, st_reg};
				lvrc_pkg::OFF_DIRECT: rdata_next = {24'h0, direct_reg};
				// Unmapped and spare offsets read as zero, no error
				default: rdata_next = lvrc_pkg::BUS_ERR_DATA;
			endcase
		end
	end

	// ----------------------------------------
	// Sequencer registers
	// ----------------------------------------
	// Cause is loaded at power-on so software sees it right after release
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cause_reg <= lvrc_pkg::CAUSE_POR_VAL;
			por_seen_reg <= 1'b1;
			st_reg <= lvrc_pkg::ST_HOLD;
		end else begin
			cause_reg <= cause_next;
			por_seen_reg <= por_seen_next;
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Control and status registers
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctl_reg <= lvrc_pkg::CTL_RESET;
			direct_reg <= 8'h00;
			stat_reg <= 3'h0;
			mask_reg <= 3'h0;
			in_stop_reg <= 1'b0;
		end else begin
			ctl_reg <= ctl_next;
			direct_reg <= direct_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			in_stop_reg <= in_stop_next;
		end
	end

	// ----------------------------------------
	// Bus answer registers
	// ----------------------------------------
	// Read data stand only in the answer cycle
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// One wait cycle then the answer; nine byte registers on aligned words
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
	assign avs_readdata_o = rdata_reg;
	assign cpu_reset_o = (st_reg != lvrc_pkg::ST_RUN);
	// Reset outranks the warning; lowest vector number wins
	assign cpu_vector_o = cpu_reset_o ? lvrc_pkg::VEC_RESET
		: (ctl_reg[lvrc_pkg::CTL_WARN_FLAG]
		&& ctl_reg[lvrc_pkg::CTL_WARN_IE]) ? lvrc_pkg::VEC_WARN
		: lvrc_pkg::VEC_NONE;
	assign cpu_irq_o = |(stat_reg & mask_reg)
		|| (ctl_reg[lvrc_pkg::CTL_WARN_FLAG]
		&& ctl_reg[lvrc_pkg::CTL_WARN_IE]);
	assign stop_granted_o = in_stop_reg;
	assign deep_stop_granted_o = in_stop_reg && !deep_block;
	assign detect_active_o = detect_on;

endmodule

// ### verification/lvrc_asserts.sv
// Checker: port-level assertions for the low-voltage reset control
`timescale 1ns/1ps
module lvrc_asserts (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// Observed ports
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire lvrc_pkg::lvrc_cmp_t cmp_i,
	input wire logic cpu_reset_o,
	input wire logic [4:0] cpu_vector_o,
	input wire logic cpu_irq_o,
	input wire logic stop_granted_o,
	input wire logic deep_stop_granted_o,
	input wire logic detect_active_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	property p_por;
		cmp_i.por_low [*3] |=> cpu_reset_o;
	endproperty
	a_por: assert property (p_por) else $error("power-on missed");
	property p_hold;
		(cmp_i.lvd_low && cpu_reset_o) [*3] |=> cpu_reset_o;
	endproperty
	a_hold: assert property (p_hold) else $error("early release");
	property p_wait;
		$rose(avs_read_i || avs_write_i) |->
			avs_waitrequest_o ##1 !avs_waitrequest_o;
	endproperty
	a_wait: assert property (p_wait) else $error("bus wait");
	property p_vec_rst;
		cpu_reset_o |-> cpu_vector_o == lvrc_pkg::VEC_RESET;
	endproperty
	a_vec_rst: assert property (p_vec_rst) else $error("vector");
	property p_vec_warn;
		cpu_vector_o == lvrc_pkg::VEC_WARN |-> cpu_irq_o && !cpu_reset_o;
	endproperty
	a_vec_warn: assert property (p_vec_warn) else $error("warn");
	property p_vec_none;
		!cpu_irq_o && !cpu_reset_o |-> cpu_vector_o == lvrc_pkg::VEC_NONE;
	endproperty
	a_vec_none: assert property (p_vec_none) else $error("idle");
	property p_deep;
		deep_stop_granted_o |-> stop_granted_o && !detect_active_o;
	endproperty
	a_deep: assert property (p_deep) else $error("deep stop");
	property p_stop;
		stop_granted_o && !deep_stop_granted_o |-> detect_active_o;
	endproperty
	a_stop: assert property (p_stop) else $error("stop detect");
	c_rel: cover property ($fell(cpu_reset_o));
	c_irq: cover property (cpu_vector_o == lvrc_pkg::VEC_WARN);
	c_deep: cover property (deep_stop_granted_o);
endmodule
bind lvrc_top lvrc_asserts u_chk (.*);

// ### verification/lvrc_core_model.sv
// Core-side model: reset sources and stop requests from the CPU
`timescale 1ns/1ps
module lvrc_core_model (
	// Clock and commands
	input wire logic clk_sys_i,
	input wire logic cpu_reset_i,
	input wire logic want_stop_i,
	input wire lvrc_pkg::lvrc_src_t want_src_i,
	// To the block
	output lvrc_pkg::lvrc_src_t src_o,
	output lvrc_pkg::lvrc_stop_t stop_o
);
	// A core held in reset runs no code, so it cannot ask to stop
	always @(posedge clk_sys_i) begin
		stop_o <= {2{want_stop_i && !cpu_reset_i}};
		src_o <= want_src_i;
	end
endmodule

// ### verification/tb.sv
// Testbench: bus, comparator pins and core model around the block
`timescale 1ns/1ps
module tb;
	logic clk_sys_i, resetn_i, rd, wr, want_stop, rst, wq, irq, stg, dstg, det;
	logic [5:0] adr;
	logic [31:0] wd, rdata, r;
	logic [4:0] vec;
	lvrc_pkg::lvrc_cmp_t cmp;
	lvrc_pkg::lvrc_src_t want_src, src;
	lvrc_pkg::lvrc_stop_t stp;
	logic [31:0] expq[$];
	int n_mismatch, n_checks, seed;
	lvrc_top dut (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.avs_address_i(adr),
		.avs_read_i(rd),
		.avs_write_i(wr),
		.avs_writedata_i(wd),
		.avs_byteenable_i(4'hf),
		.avs_readdata_o(rdata),
		.avs_waitrequest_o(wq),
		.cmp_i(cmp),
		.src_i(src),
		.stop_i(stp),
		.cpu_reset_o(rst),
		.cpu_vector_o(vec),
		.cpu_irq_o(irq),
		.stop_granted_o(stg),
		.deep_stop_granted_o(dstg),
		.detect_active_o(det)
	);
	lvrc_core_model core (
		.clk_sys_i(clk_sys_i),
		.cpu_reset_i(rst),
		.want_stop_i(want_stop),
		.want_src_i(want_src),
		.src_o(src),
		.stop_o(stp)
	);
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(logic w, logic [5:0] a, logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_sys_i);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		@(posedge clk_sys_i);
		while (wq !== 1'b0 && t < 50) begin
			@(posedge clk_sys_i);
			t++;
		end
		if (t >= 50) chk("waitrequest", 0, wq);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rdx(logic [5:0] a, logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic pins(logic [3:0] v, int n);
		@(posedge clk_sys_i);
		cmp <= v;
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic wt(logic v, int n);
		repeat (n) if (rst !== v) @(negedge clk_sys_i);
		chk("cpu_reset", v, rst);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Sampled on the edge where the slave ends its wait
	always @(posedge clk_sys_i) begin
		if (rd === 1'b1 && wq === 1'b0) chk("readdata", expq.pop_front(), rdata);
	end
	initial begin
		clk_sys_i = 0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		repeat (3000) @(posedge clk_sys_i);
		n_mismatch++;
		end_sim();
	end
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		seed = 71;
		{rd, wr, adr, wd, want_stop, want_src} = '0;
		cmp = 4'hc;
		resetn_i = 0;
		repeat (10) @(posedge clk_sys_i);
		resetn_i <= 1;
		pins(4'h4, 6);
		chk("cpu_reset", 1, rst);
		pins(4'h0, 0);
		wt(0, 20);
		rdx(lvrc_pkg::OFF_CAUSE, 32'h82);
		rdx(lvrc_pkg::OFF_PWR_CTRL, 32'h1d);
		bus(1, lvrc_pkg::OFF_CAUSE, 32'h0);
		rdx(lvrc_pkg::OFF_CAUSE, 32'h82);
		rdx(6'h3c, 32'h0);
		repeat (3) begin
			r = $random(seed);
			bus(1, lvrc_pkg::OFF_DIRECT, r);
			rdx(lvrc_pkg::OFF_DIRECT, r & 32'hff);
		end
		bus(1, lvrc_pkg::OFF_IRQ_MASK, 32'h0);
		pins(4'h1, 4);
		chk("irq", 1, irq);
		chk("vector", lvrc_pkg::VEC_WARN, vec);
		rdx(lvrc_pkg::OFF_PWR_CTRL, 32'h3d);
		pins(4'h0, 3);
		bus(1, lvrc_pkg::OFF_PWR_CTRL, 32'h3d);
		@(negedge clk_sys_i);
		chk("irq", 0, irq);
		bus(1, lvrc_pkg::OFF_PWR_CTRL, 32'h0d);
		pins(4'h1, 4);
		chk("irq", 0, irq);
		pins(4'h0, 3);
		bus(1, lvrc_pkg::OFF_PWR_CTRL, 32'h15);
		pins(4'h2, 8);
		chk("cpu_reset", 0, rst);
		pins(4'h6, 0);
		wt(1, 8);
		pins(4'h0, 0);
		wt(0, 20);
		rdx(lvrc_pkg::OFF_CAUSE, 32'h82);
		rdx(lvrc_pkg::OFF_PWR_CTRL, 32'h1d);
		chk("detect", 1, det);
		bus(1, lvrc_pkg::OFF_PWR_CTRL, 32'h1c);
		pins(4'h6, 8);
		chk("detect", 0, det);
		chk("cpu_reset", 0, rst);
		pins(4'h0, 3);
		bus(1, lvrc_pkg::OFF_PWR_CTRL, 32'h1d);
		want_stop <= 1;
		repeat (4) @(negedge clk_sys_i);
		chk("stop", 3'b101, {stg, det, dstg});
		@(posedge clk_sys_i);
		want_stop <= 0;
		bus(1, lvrc_pkg::OFF_PWR_CTRL, 32'h1f);
		want_stop <= 1;
		repeat (4) @(negedge clk_sys_i);
		chk("stop", 3'b110, {stg, det, dstg});
		@(posedge clk_sys_i);
		want_stop <= 0;
		rdx(lvrc_pkg::OFF_IRQ_STAT, 32'h7);
		bus(1, lvrc_pkg::OFF_IRQ_MASK, 32'h4);
		@(negedge clk_sys_i);
		chk("irq", 1, irq);
		bus(1, lvrc_pkg::OFF_IRQ_STAT, 32'h4);
		@(negedge clk_sys_i);
		chk("irq", 0, irq);
		@(posedge clk_sys_i);
		want_src <= 4'h8;
		wt(1, 8);
		chk("vector", lvrc_pkg::VEC_RESET, vec);
		@(posedge clk_sys_i);
		want_src <= 4'h0;
		wt(0, 20);
		rdx(lvrc_pkg::OFF_CAUSE, 32'h40);
		end_sim();
	end
endmodule
